// file: mpa_pkg.sv
// ============================================================
// Shared constants and types for the memory pointer block
package mpa_pkg;

  // ============================================================
  // Program space
  localparam logic [15:0] MPA_IP_RESET       = 16'h8000;  // First boot ROM word
  localparam logic [15:0] MPA_USER_START     = 16'h0000;  // User code entry
  localparam logic [3:0]  MPA_ROM_NIBBLE     = 4'h8;      // Boot ROM 8000h..8FFFh
  localparam int          MPA_ROM_WORDS      = 4096;      // 4k x 16 boot ROM
  localparam logic [15:0] MPA_STEP_UP        = 16'h0001;  // Add one
  localparam logic [15:0] MPA_STEP_DOWN      = 16'hFFFF;  // Subtract one, modulo 2^16

  // ============================================================
  // Program flash page layout (256 pages of 32 words)
  localparam int MPA_PFLASH_PAGES      = 256;
  localparam int MPA_PFLASH_PAGE_WORDS = 32;
  localparam int MPA_PFLASH_PAGE_LSB   = 5;
  localparam int MPA_PFLASH_PAGE_MSB   = 12;
  localparam int MPA_PFLASH_ERASE_PAGES = 2;  // Erase clears a pair of pages

  // ============================================================
  // Data space
  localparam int          MPA_SRAM_WORDS       = 256;       // 256 x 16 data SRAM
  localparam logic [15:0] MPA_SRAM_BASE        = 16'h0000;
  localparam logic [15:0] MPA_DEBUG_FIRST_BYTE = 16'h01ED;  // Kept free for debug
  localparam logic [15:0] MPA_DEBUG_LAST_BYTE  = 16'h01FF;
  localparam logic [15:0] MPA_DFLASH_BASE      = 16'h4000;
  localparam logic [15:0] MPA_DFLASH_LAST      = 16'h407F;  // Regular mode
  localparam logic [15:0] MPA_DFLASH_LAST_EVEN = 16'h407E;  // Even mode
  localparam int          MPA_DFLASH_PAGES     = 128;
  localparam int          MPA_DFLASH_PAGES_EVEN = 64;

  // ============================================================
  // Timing in clock cycles (200 MHz)
  localparam int MPA_READ_LATENCY = 2;  // Request edge to rdValid

  // ============================================================
  // Pointer selection for an indirect access
  typedef enum logic [1:0] {
    MPA_SRC_DP0,
    MPA_SRC_DP1,
    MPA_SRC_FRAME
  } mpa_src_t;

  // Automatic modification of the pointer
  typedef enum logic [1:0] {
    MPA_MOD_NONE,
    MPA_MOD_INC,
    MPA_MOD_DEC
  } mpa_mod_t;

  // Direct software load of a pointer register
  typedef enum logic [2:0] {
    MPA_LOAD_NONE,
    MPA_LOAD_DP0,
    MPA_LOAD_DP1,
    MPA_LOAD_BASE,
    MPA_LOAD_DISP
  } mpa_load_t;

endpackage

// file: mpa_sram_if.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port between the address logic and the data SRAM
interface mpa_sram_if #(parameter int AW = 8);
  logic          en;     // Access this cycle
  logic          we;     // Write when set
  logic [1:0]    be;     // Byte lanes
  logic [AW-1:0] addr;   // Word index
  logic [15:0]   wdata;  // Write word
  logic [15:0]   rdata;  // Registered read word
  modport ctrl (output en, output we, output be, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input be, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: mpa_sram_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Data SRAM, one clock per access, byte lanes
module mpa_sram_mem
  import mpa_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8
)(
  input wire logic clock,
  mpa_sram_if.mem  port
);

  logic [15:0] store [DEPTH];  // Array has no reset so it survives warm resets

  // ============================================================
  // Single-period read or write; contents kept through any reset
  always_ff @(posedge clock)
  begin
    if (port.en)
    begin
      if (port.we)
      begin
        if (port.be[0])
          store[port.addr][7:0] <= port.wdata[7:0];  // Low lane
        if (port.be[1])
          store[port.addr][15:8] <= port.wdata[15:8];  // High lane
      end
      else
        port.rdata <= store[port.addr];
    end
  end

endmodule
`default_nettype wire

// file: mpa_pointer_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Program address sixteen bits, 64k words
// - Written pointer fetched on next cycle
// - Instruction pointer adds one per fetch
// - Reset loads instruction pointer with 8000h
// - 4k word boot ROM at 8000h
// - Loader request bit resets to zero
// - 256 word data SRAM from 0000h
// - SRAM kept across stop and warm resets
// - Pointer source reads, destination writes memory
// - Two data pointers with auto modify
// - Post modify on read, pre on write
// - Frame address is base plus displacement
// - Displacement modified before write, after read
// - Frame carry never reaches the base
// - SRAM access in one clock period
// - Word or byte data accesses
// - Mapped flash readable, never written here
// - Program flash in 256 pages of 32
// - Regular data flash pages 4000h to 407Fh
// - Even mode pages at even 4000h to 407Eh
module mpa_pointer_unit
  import mpa_pkg::*;
#(
  parameter int DISP_WIDTH = 8,               // Frame displacement width
  parameter int SRAM_WORDS = MPA_SRAM_WORDS,  // Data SRAM depth
  parameter int SRAM_AW    = $clog2(SRAM_WORDS)
)(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  stopMode,
  input  wire logic                  fetchEn,
  input  wire logic                  ipWrite,
  input  wire logic [15:0]           ipWriteData,
  input  wire logic                  loaderSet,
  input  wire logic                  loaderClear,
  input  wire mpa_load_t             loadSel,
  input  wire logic [15:0]           loadData,
  input  wire logic                  accValid,
  input  wire logic                  accWrite,
  input  wire logic                  accByte,
  input  wire mpa_src_t              accSrc,
  input  wire mpa_mod_t              accMod,
  input  wire logic [15:0]           accWriteData,
  input  wire logic                  evenMode,
  input  wire logic [15:0]           flashReadData,
  output logic [15:0]                programAddress,
  output logic                       bootRomSelect,
  output logic [7:0]                 flashPage,
  output logic                       bootLoaderRequestBit,
  output logic [15:0]                dataPointer0,
  output logic [15:0]                dataPointer1,
  output logic [15:0]                frameBase,
  output logic [DISP_WIDTH-1:0]      frameDisplacement,
  output logic                       flashReadEn,
  output logic [15:0]                flashReadAddr,
  output logic                       rdValid,
  output logic [15:0]                rdData
);

  // ============================================================
  // Internal signals
  mpa_sram_if #(.AW(SRAM_AW)) sramPort ();     // Link to the data SRAM

  logic [15:0]           next_programAddress;  // Address of the next fetch
  logic [15:0]           step;                 // Plus or minus one
  logic                  modify;               // Access changes its pointer
  logic [15:0]           dpSelected;           // Chosen data pointer
  logic [15:0]           dpStepped;            // Chosen pointer after a step
  logic [DISP_WIDTH-1:0] dispStepped;          // Displacement after a step
  logic [15:0]           effAddr;              // Address the access uses
  logic [15:0]           wordIdx;              // Word index in data space
  logic                  lane;                 // High byte selected
  logic                  hitSram;              // Address lands in SRAM
  logic                  hitFlash;             // Address lands in data flash
  logic                  pendRead;             // Read in flight, stage one
  logic                  pendSram;             // In-flight read came from SRAM
  logic                  pendLane;             // In-flight byte lane
  logic                  pendByte;             // In-flight read is a byte
  logic [15:0]           rawWord;              // Word before byte alignment

  // ============================================================
  // Instruction pointer
  // Write wins over the increment so the next fetch uses the new address
  always_comb
  begin
    if (ipWrite)
      next_programAddress = ipWriteData;
    else if (fetchEn)
      next_programAddress = 16'(programAddress + MPA_STEP_UP);
    else
      next_programAddress = programAddress;
  end

  // Sixteen-bit pointer over a linear 64k word space
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      programAddress <= MPA_IP_RESET;
    else
      programAddress <= next_programAddress;
  end

  // Region flags follow the pointer so they never lag a fetch
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bootRomSelect <= 1'b1;
      flashPage     <= MPA_IP_RESET[MPA_PFLASH_PAGE_MSB:MPA_PFLASH_PAGE_LSB];
    end
    else
    begin
      // Boot ROM occupies 8000h..8FFFh
      bootRomSelect <= (next_programAddress[15:12] == MPA_ROM_NIBBLE);
      // Page of 32 words inside the program flash
      flashPage     <= next_programAddress[MPA_PFLASH_PAGE_MSB:MPA_PFLASH_PAGE_LSB];
    end
  end

  // ============================================================
  // Boot loader request bit
  // Set beats clear so a request that meets a clear is not lost
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      bootLoaderRequestBit <= 1'b0;
    else if (loaderSet)
      bootLoaderRequestBit <= 1'b1;  // Test port request
    else if (loaderClear)
      bootLoaderRequestBit <= 1'b0;  // Loader done
  end

  // ============================================================
  // Address generation
  always_comb
  begin
    step   = (accMod == MPA_MOD_DEC) ? MPA_STEP_DOWN : MPA_STEP_UP;
    modify = accValid && (accMod != MPA_MOD_NONE);
    // Pick one of the two data pointers
    dpSelected = (accSrc == MPA_SRC_DP1) ? dataPointer1 : dataPointer0;
    // Wraps modulo 2^16, no flag
    dpStepped   = 16'(dpSelected + step);
    // Only the displacement moves; carry is dropped here
    dispStepped = DISP_WIDTH'(frameDisplacement + step[DISP_WIDTH-1:0]);
    if (accSrc == MPA_SRC_FRAME)
    begin
      // Pre-modify for writes, old value for reads
      effAddr = 16'(frameBase + 16'((accWrite && modify) ? dispStepped
                                                        : frameDisplacement));
    end
    else
      effAddr = (accWrite && modify) ? dpStepped : dpSelected;
    // Byte accesses resolve a byte address to word and lane
    wordIdx = accByte ? {1'b0, effAddr[15:1]} : effAddr;
    lane    = accByte && effAddr[0];
    hitSram = (wordIdx[15:SRAM_AW] == '0);
    // Flash window; even mode skips odd words
    hitFlash = (wordIdx >= MPA_DFLASH_BASE) && (wordIdx <= MPA_DFLASH_LAST)
               && !(evenMode && wordIdx[0]);
  end

  // ============================================================
  // SRAM request, driven in the request cycle
  // Stop mode blocks all strobes, keeping contents intact
  always_comb
  begin
    sramPort.en    = accValid && hitSram && !stopMode;
    sramPort.we    = accWrite;                          // Destination stores
    sramPort.be    = accByte ? (lane ? 2'b10 : 2'b01) : 2'b11;
    sramPort.addr  = wordIdx[SRAM_AW-1:0];
    sramPort.wdata = accByte ? {2{accWriteData[7:0]}} : accWriteData;
  end

  mpa_sram_mem #(
    .DEPTH (SRAM_WORDS),
    .AW    (SRAM_AW)
  ) u_sram (
    .clock (clock),
    .port  (sramPort)
  );

  // ============================================================
  // Data pointers: access modification first, direct load wins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dataPointer0 <= 16'h0000;
      dataPointer1 <= 16'h0000;
    end
    else
    begin
      // Post step after a read, pre step before a write
      if (modify && accSrc == MPA_SRC_DP0)
        dataPointer0 <= dpStepped;
      if (modify && accSrc == MPA_SRC_DP1)
        dataPointer1 <= dpStepped;
      if (loadSel == MPA_LOAD_DP0)
        dataPointer0 <= loadData;
      if (loadSel == MPA_LOAD_DP1)
        dataPointer1 <= loadData;
    end
  end

  // Frame pointer registers; base only ever changes by a load
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frameBase         <= 16'h0000;
      frameDisplacement <= '0;
    end
    else
    begin
      if (modify && accSrc == MPA_SRC_FRAME)
        frameDisplacement <= dispStepped;
      if (loadSel == MPA_LOAD_BASE)
        frameBase <= loadData;
      if (loadSel == MPA_LOAD_DISP)
        frameDisplacement <= loadData[DISP_WIDTH-1:0];
    end
  end

  // ============================================================
  // Read pipeline, stage one: SRAM word and flash address
  // Flash writes are dropped: only the boot ROM may program it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendRead      <= 1'b0;
      pendSram      <= 1'b0;
      pendLane      <= 1'b0;
      pendByte      <= 1'b0;
      flashReadEn   <= 1'b0;
      flashReadAddr <= MPA_DFLASH_BASE;
    end
    else
    begin
      pendRead    <= accValid && !accWrite;
      pendSram    <= accValid && !accWrite && hitSram && !stopMode;
      pendLane    <= lane;
      pendByte    <= accByte;
      flashReadEn <= accValid && !accWrite && hitFlash;
      if (accValid && !accWrite && hitFlash)
        flashReadAddr <= wordIdx;
    end
  end

  // Unmapped and blocked reads return zero
  always_comb
  begin
    if (pendSram)
      rawWord = sramPort.rdata;
    else if (flashReadEn)
      rawWord = flashReadData;
    else
      rawWord = 16'h0000;
  end

  // Stage two: align the byte and present the result
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdValid <= 1'b0;
      rdData  <= 16'h0000;
    end
    else
    begin
      rdValid <= pendRead;
      if (pendRead)
        rdData <= pendByte ? {8'h00, (pendLane ? rawWord[15:8] : rawWord[7:0])}
                           : rawWord;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // A read that lands in SRAM
  sequence seq_sram_read;
    accValid && !accWrite && hitSram && !stopMode;
  endsequence

  // A read that lands in data flash
  sequence seq_flash_read;
    accValid && !accWrite && hitFlash;
  endsequence

  // Post increment read through the first data pointer
  sequence seq_dp0_post_inc;
    accValid && !accWrite && accSrc == MPA_SRC_DP0 && accMod == MPA_MOD_INC
      && loadSel == MPA_LOAD_NONE;
  endsequence

  chk_ip_write_redirect: assert property (
    ipWrite |=> programAddress == $past(ipWriteData))
    else $error("fetch address ignores pointer write");

  chk_ip_fetch_step: assert property (
    fetchEn && !ipWrite |=> programAddress == 16'($past(programAddress) + 16'h0001))
    else $error("fetch did not advance pointer by one");

  chk_rom_flag_match: assert property (
    bootRomSelect == (programAddress[15:12] == MPA_ROM_NIBBLE))
    else $error("boot ROM flag disagrees with pointer");

  chk_loader_bit_set: assert property (
    loaderSet |=> bootLoaderRequestBit)
    else $error("loader request was lost");

  chk_dp_post_read: assert property (
    seq_dp0_post_inc |-> effAddr == dataPointer0 ##1
      dataPointer0 == 16'($past(dataPointer0) + 16'h0001))
    else $error("post increment read misbehaved");

  chk_dp_wrap_down: assert property (
    accValid && accSrc == MPA_SRC_DP0 && accMod == MPA_MOD_DEC
      && dataPointer0 == 16'h0000 && loadSel == MPA_LOAD_NONE
      |=> dataPointer0 == 16'hFFFF)
    else $error("decrement from zero did not wrap");

  chk_frame_base_kept: assert property (
    accValid && accSrc == MPA_SRC_FRAME && accMod != MPA_MOD_NONE
      && loadSel == MPA_LOAD_NONE |=> $stable(frameBase))
    else $error("frame step disturbed the base");

  chk_frame_sum: assert property (
    accValid && accSrc == MPA_SRC_FRAME && (accMod == MPA_MOD_NONE || !accWrite)
      |-> effAddr == 16'(frameBase + 16'(frameDisplacement)))
    else $error("frame address is not base plus displacement");

  chk_sram_read_time: assert property (
    seq_sram_read ##1 pendSram |=> rdValid)
    else $error("SRAM read result late");

  chk_flash_read_path: assert property (
    seq_flash_read |=> flashReadEn ##1 rdValid)
    else $error("flash read did not complete");

endmodule
`default_nettype wire

// file: mpa_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Data flash as seen by the read path of the pointer block
module mpa_flash_model
(
  input  wire logic        clock,
  input  wire logic        readEn,
  input  wire logic [15:0] readAddr,
  output logic [15:0]      readData
);
  logic [15:0] lastWord = 16'h0000;  // Last word handed out

  // Stored word is a fixed function of its address, readable in place
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return a ^ 16'h5AC3;
  endfunction

  // Remember the last word so that idle cycles can show its inverse
  always_ff @(posedge clock)
  begin
    if (readEn)
    begin
      lastWord <= word_at(readAddr);
    end
  end

  // Answer in the same cycle; an idle bus never repeats stale data
  assign readData = readEn ? word_at(readAddr) : ~lastWord;
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the pointer and address block
module tb_top
  import mpa_pkg::*;
;
  logic        clock, reset_n, stopMode, fetchEn, ipWrite, loaderSet, loaderClear;
  logic        accValid, accWrite, accByte, evenMode;
  logic        rdValid, flashReadEn, bootRomSelect, bootLoaderRequestBit;
  logic [15:0] ipWriteData, loadData, accWriteData, flashReadData, programAddress;
  logic [15:0] dataPointer0, dataPointer1, frameBase, flashReadAddr, rdData;
  logic [7:0]  flashPage, frameDisplacement;
  mpa_load_t   loadSel;
  mpa_src_t    accSrc;
  mpa_mod_t    accMod;
  int          err_count = 0;  // Mismatches seen
  int          n_checks  = 0;  // Comparisons made

  mpa_pointer_unit uut (
    .clock(clock), .reset_n(reset_n), .stopMode(stopMode), .fetchEn(fetchEn),
    .ipWrite(ipWrite), .ipWriteData(ipWriteData), .loaderSet(loaderSet),
    .loaderClear(loaderClear), .loadSel(loadSel), .loadData(loadData),
    .accValid(accValid), .accWrite(accWrite), .accByte(accByte), .accSrc(accSrc),
    .accMod(accMod), .accWriteData(accWriteData), .evenMode(evenMode),
    .flashReadData(flashReadData), .programAddress(programAddress),
    .bootRomSelect(bootRomSelect), .flashPage(flashPage),
    .bootLoaderRequestBit(bootLoaderRequestBit), .dataPointer0(dataPointer0),
    .dataPointer1(dataPointer1), .frameBase(frameBase),
    .frameDisplacement(frameDisplacement), .flashReadEn(flashReadEn),
    .flashReadAddr(flashReadAddr), .rdValid(rdValid), .rdData(rdData)
  );

  mpa_flash_model flash (
    .clock(clock), .readEn(flashReadEn), .readAddr(flashReadAddr), .readData(flashReadData)
  );

  // ============================================================
  // Clock, 5 ns period
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ============================================================
  // Shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic step;
    @(posedge clock);
    #1;
  endtask

  task automatic load(input mpa_load_t sel, input logic [15:0] d);
    loadSel  = sel;
    loadData = d;
    step;
    loadSel  = MPA_LOAD_NONE;
    step;  // Idle edge: back-to-back loads never move the select twice at once
  endtask

  // One indirect access, held for exactly one request edge, then one idle edge
  task automatic access(input logic wr, input logic byt, input mpa_src_t src,
                        input mpa_mod_t md, input logic [15:0] d);
    accValid     = 1'b1;
    accWrite     = wr;
    accByte      = byt;
    accSrc       = src;
    accMod       = md;
    accWriteData = d;
    step;
    accValid     = 1'b0;
    step;  // Idle edge so a following request starts in a later time step
  endtask

  // Read and wait, bounded, for the answer; latency is fixed at two
  task automatic rd(input mpa_src_t src, input mpa_mod_t md, input logic byt,
                    input logic [15:0] exp);
    int n;
    access(1'b0, byt, src, md, 16'h0000);
    n = 2;  // Access already spans the request edge and the one after it
    while (rdValid !== 1'b1 && n < 6)
    begin
      step;
      n++;
    end
    chk(16'(n), 16'h0002);
    chk(rdData, exp);
  endtask

  task automatic print_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset;
    chk(programAddress, 16'h8000);
    chk(16'(bootRomSelect), 16'h0001);
    chk(16'(bootLoaderRequestBit), 16'h0000);
    chk(dataPointer1, 16'h0000);
  endtask

  task automatic t_fetch;
    fetchEn = 1'b1;
    repeat (3) step;
    fetchEn = 1'b0;
    chk(programAddress, 16'h8003);
    // Write and fetch together: the write wins
    ipWrite     = 1'b1;
    ipWriteData = 16'h8FFF;
    fetchEn     = 1'b1;
    step;
    ipWrite = 1'b0;
    chk(programAddress, 16'h8FFF);
    chk(16'(bootRomSelect), 16'h0001);
    step;
    fetchEn = 1'b0;
    chk(programAddress, 16'h9000);
    chk(16'(bootRomSelect), 16'h0000);
    ipWrite     = 1'b1;
    ipWriteData = 16'h1FE0;
    step;
    chk(16'(flashPage), 16'h00FF);
    ipWriteData = 16'hFFFF;
    step;
    ipWrite = 1'b0;
    fetchEn = 1'b1;
    step;
    fetchEn = 1'b0;
    chk(programAddress, 16'h0000);
  endtask

  task automatic t_loader;
    loaderSet   = 1'b1;
    loaderClear = 1'b1;
    step;
    loaderSet = 1'b0;
    chk(16'(bootLoaderRequestBit), 16'h0001);
    step;
    loaderClear = 1'b0;
    chk(16'(bootLoaderRequestBit), 16'h0000);
  endtask

  task automatic t_pointer;
    load(MPA_LOAD_DP0, 16'h0010);
    access(1'b1, 1'b0, MPA_SRC_DP0, MPA_MOD_INC, 16'hBEEF);
    chk(dataPointer0, 16'h0011);
    load(MPA_LOAD_DP1, 16'h0011);
    rd(MPA_SRC_DP1, MPA_MOD_DEC, 1'b0, 16'hBEEF);
    chk(dataPointer1, 16'h0010);
    chk(dataPointer0, 16'h0011);
    // Top SRAM word, then the first word past it
    load(MPA_LOAD_DP0, 16'h00FF);
    access(1'b1, 1'b0, MPA_SRC_DP0, MPA_MOD_NONE, 16'hA55A);  // No debug session here
    rd(MPA_SRC_DP0, MPA_MOD_INC, 1'b0, 16'hA55A);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b0, 16'h0000);
  endtask

  task automatic t_byte;
    load(MPA_LOAD_DP0, 16'h0023);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b1, 16'h00BE);
    access(1'b1, 1'b1, MPA_SRC_DP0, MPA_MOD_DEC, 16'h005A);
    chk(dataPointer0, 16'h0022);
    load(MPA_LOAD_DP1, 16'h0011);
    rd(MPA_SRC_DP1, MPA_MOD_NONE, 1'b0, 16'hBE5A);
  endtask

  // Base plus displacement overflows 16 bits and lands on word 0011h
  task automatic t_frame;
    load(MPA_LOAD_BASE, 16'hFF12);
    load(MPA_LOAD_DISP, 16'h00FF);
    rd(MPA_SRC_FRAME, MPA_MOD_INC, 1'b0, 16'hBE5A);
    chk(16'(frameDisplacement), 16'h0000);
    chk(frameBase, 16'hFF12);
    access(1'b1, 1'b0, MPA_SRC_FRAME, MPA_MOD_DEC, 16'h1234);
    chk(16'(frameDisplacement), 16'h00FF);
    chk(frameBase, 16'hFF12);
    load(MPA_LOAD_DP0, 16'h0011);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b0, 16'h1234);
  endtask

  task automatic t_flash;
    load(MPA_LOAD_DP0, 16'h4005);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b0, 16'h4005 ^ 16'h5AC3);
    evenMode = 1'b1;
    rd(MPA_SRC_DP0, MPA_MOD_INC, 1'b0, 16'h0000);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b0, 16'h4006 ^ 16'h5AC3);
    evenMode = 1'b0;
    load(MPA_LOAD_DP0, 16'h407F);
    rd(MPA_SRC_DP0, MPA_MOD_INC, 1'b0, 16'h407F ^ 16'h5AC3);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b0, 16'h0000);
    chk(flashReadAddr, 16'h407F);  // Miss leaves last flash address
  endtask

  // Stop mode and a warm reset must both leave SRAM alone
  task automatic t_retain;
    load(MPA_LOAD_DP0, 16'h0011);
    stopMode = 1'b1;
    access(1'b1, 1'b0, MPA_SRC_DP0, MPA_MOD_NONE, 16'hFFFF);
    rd(MPA_SRC_DP0, MPA_MOD_NONE, 1'b0, 16'h0000);
    stopMode = 1'b0;
    reset_n  = 1'b0;
    loaderSet = 1'b1;  // Test port holds its request through reset
    repeat (2) step;
    chk(16'(bootLoaderRequestBit), 16'h0000);
    reset_n = 1'b1;
    chk(programAddress, 16'h8000);
    step;
    loaderSet = 1'b0;
    chk(16'(bootLoaderRequestBit), 16'h0001);
    load(MPA_LOAD_DP1, 16'h0011);
    rd(MPA_SRC_DP1, MPA_MOD_NONE, 1'b0, 16'h1234);
    // Pointer at zero after reset steps down to all ones
    access(1'b0, 1'b0, MPA_SRC_DP0, MPA_MOD_DEC, 16'h0000);
    chk(dataPointer0, 16'hFFFF);
    repeat (2) step;
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    {reset_n, stopMode, fetchEn, ipWrite, loaderSet, loaderClear} = 6'h00;
    {accValid, accWrite, accByte, evenMode} = 4'h0;
    {ipWriteData, loadData, accWriteData} = 48'h0;
    loadSel = MPA_LOAD_NONE;
    accSrc  = MPA_SRC_DP0;
    accMod  = MPA_MOD_NONE;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_reset;
    t_fetch;
    t_loader;
    t_pointer;
    t_byte;
    t_frame;
    t_flash;
    t_retain;
    print_verdict;
  end

  // Whole run needs under a hundred cycles; cut a hang well beyond that
  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
